// ==== core/mfsc_defines.svh ====
// Purpose: constants for the mmu fault status capture block
// Assumes: 64-bit status registers, fields at fixed bit positions
// Notes: the package holds the types
`ifndef MFSC_DEFINES_SVH
`define MFSC_DEFINES_SVH
`define MFSC_ADDR_ISTAT 4'h0
`define MFSC_ADDR_DSTAT 4'h1
`define MFSC_ADDR_IRQ_STAT 4'h2
`define MFSC_ADDR_IRQ_MASK 4'h3
`define MFSC_FT_NONE 7'h00
`define MFSC_FT_PRIV 7'h01
`define MFSC_CT_NONTRANS 2'h3
`define MFSC_SEL_FULL 2'h0
`define MFSC_SEL_SET 2'h2
`define MFSC_B_FV 0
`define MFSC_B_OW 1
`define MFSC_B_PR 3
`define MFSC_B_CT 4
`define MFSC_B_FT 7
`define MFSC_B_TM 15
`define MFSC_B_ASI 16
`define MFSC_B_NC 25
`define MFSC_B_ITLB 26
`define MFSC_B_BUS 29
`define MFSC_B_UE 31
`define MFSC_B_IDX 49
`define MFSC_B_SEL 62
`define MFSC_IRQ_W 4
`endif

// ==== core/mfsc_pkg.sv ====
// Purpose: types for the mmu fault status capture block
// Assumes: nothing
// Notes: none
package mfsc_pkg;
   typedef enum logic [1:0] {MFSC_EV_NONE, MFSC_EV_MISS, MFSC_EV_EXC, MFSC_EV_ERR} mfsc_ev_t;
endpackage : mfsc_pkg

// ==== core/mfsc_capture.sv ====
// Purpose: instruction and data mmu fault status capture with register port
// Assumes: one trap at most per cycle, priority error > exception > miss
// Notes: reads of the interrupt status register clear it, keeping only events of that cycle
`timescale 1ns/1ps
`include "mfsc_defines.svh"
module mfsc_capture #(
   parameter int IDX_W = 11
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic trap_miss,
   input wire logic trap_exc,
   input wire logic trap_err,
   input wire logic page_privileged_bit,
   input wire logic cpu_privileged_bit,
   input wire logic [1:0] ref_context,
   input wire logic ref_asi_translating,
   input wire logic [7:0] ref_asi,
   input wire logic err_uncorrectable,
   input wire logic [1:0] err_bus_response,
   input wire logic [1:0] err_itlb,
   input wire logic err_noncacheable,
   input wire logic [1:0] itlb_select,
   input wire logic [IDX_W-1:0] itlb_index,
   input wire logic dtlb_err,
   input wire logic fa_parity,
   input wire logic [IDX_W-1:0] fa_parity_idx,
   input wire logic sa_parity,
   input wire logic [IDX_W-1:0] sa_parity_idx,
   input wire logic [(1<<IDX_W)-1:0] fa_hit_vec,
   input wire logic [(1<<IDX_W)-1:0] sa_hit_vec,
   input wire logic [3:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [63:0] reg_rdata,
   output logic irq
);
   localparam int N = 1 << IDX_W;
   logic [63:0] instr_fault_status_reg;
   logic [63:0] data_fault_status_reg;
   logic [`MFSC_IRQ_W-1:0] irq_stat;
   logic [`MFSC_IRQ_W-1:0] irq_mask;
   mfsc_pkg::mfsc_ev_t ev;
   logic illegal_asi;
   logic fv;
   logic tm;
   logic [1:0] next_ct;
   logic next_pr;
   logic [6:0] next_ft;
   logic fa_mh;
   logic sa_mh;
   logic [IDX_W-1:0] fa_low;
   logic [IDX_W-1:0] sa_low;
   logic [1:0] next_dsel;
   logic [IDX_W-1:0] next_didx;
   logic dlog;

   assign fv = instr_fault_status_reg[`MFSC_B_FV];
   assign tm = instr_fault_status_reg[`MFSC_B_TM];

   always_comb begin
      if (trap_err) begin
         ev = mfsc_pkg::MFSC_EV_ERR;
      end else if (trap_exc) begin
         ev = mfsc_pkg::MFSC_EV_EXC;
      end else if (trap_miss) begin
         ev = mfsc_pkg::MFSC_EV_MISS;
      end else begin
         ev = mfsc_pkg::MFSC_EV_NONE;
      end
   end

   // illegal address space values
   always_comb begin
      illegal_asi = (ref_asi <= 8'h03) || (ref_asi >= 8'h12 && ref_asi <= 8'h13) ||
         (ref_asi >= 8'h16 && ref_asi <= 8'h17) || (ref_asi >= 8'h1a && ref_asi <= 8'h1b) ||
         (ref_asi >= 8'h1e && ref_asi <= 8'h23) || (ref_asi >= 8'h2d && ref_asi <= 8'h2f) ||
         (ref_asi >= 8'h35 && ref_asi <= 8'h3b);
      next_ct = (!ref_asi_translating || illegal_asi) ? `MFSC_CT_NONTRANS : ref_context;
      next_pr = cpu_privileged_bit;
      // only privilege violation is ever encoded
      next_ft = (page_privileged_bit && !cpu_privileged_bit) ? `MFSC_FT_PRIV
         : `MFSC_FT_NONE;
   end

   // instruction status capture
   always_ff @(posedge mclk) begin
      if (srst) begin
         instr_fault_status_reg <= 64'h0;
      end else if (ev != mfsc_pkg::MFSC_EV_NONE) begin
         case (ev)
            mfsc_pkg::MFSC_EV_MISS: begin
               instr_fault_status_reg[`MFSC_B_TM] <= 1'b1;
               instr_fault_status_reg[`MFSC_B_FT +: 7] <= fv ?
                  instr_fault_status_reg[`MFSC_B_FT +: 7] : `MFSC_FT_NONE;
               if (!fv) begin
                  instr_fault_status_reg[`MFSC_B_PR] <= next_pr;
                  instr_fault_status_reg[`MFSC_B_CT +: 2] <= next_ct;
                  if (!tm) begin
                     instr_fault_status_reg[`MFSC_B_OW] <= 1'b0;
                  end
               end
            end
            mfsc_pkg::MFSC_EV_EXC, mfsc_pkg::MFSC_EV_ERR: begin
               instr_fault_status_reg[`MFSC_B_FV] <= 1'b1;
               instr_fault_status_reg[`MFSC_B_OW] <= fv ? 1'b1 :
                  (tm ? instr_fault_status_reg[`MFSC_B_OW] : 1'b0);
               if (!fv && !tm) begin
                  instr_fault_status_reg[`MFSC_B_TM] <= 1'b0;
               end
               instr_fault_status_reg[`MFSC_B_PR] <= next_pr;
               instr_fault_status_reg[`MFSC_B_CT +: 2] <= next_ct;
               instr_fault_status_reg[`MFSC_B_ASI +: 8] <= ref_asi;
               if (ev == mfsc_pkg::MFSC_EV_EXC) begin
                  instr_fault_status_reg[`MFSC_B_FT +: 7] <= next_ft;
               end else begin
                  // error detail fields only meaningful here
                  instr_fault_status_reg[`MFSC_B_UE] <= err_uncorrectable;
                  instr_fault_status_reg[`MFSC_B_BUS +: 2] <= err_bus_response;
                  instr_fault_status_reg[`MFSC_B_ITLB +: 2] <= err_itlb;
                  instr_fault_status_reg[`MFSC_B_NC] <= err_noncacheable;
                  if (err_itlb != 2'h0) begin
                     instr_fault_status_reg[`MFSC_B_SEL +: 2] <= itlb_select;
                     instr_fault_status_reg[`MFSC_B_IDX +: IDX_W] <= itlb_index;
                  end
               end
            end
            default: begin
               instr_fault_status_reg <= instr_fault_status_reg;
            end
         endcase
      end else if (reg_wr && reg_addr == `MFSC_ADDR_ISTAT) begin
         instr_fault_status_reg <= reg_wdata;
      end
   end

   // lowest matching index of a multiple hit
   always_comb begin
      fa_low = '0;
      sa_low = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (fa_hit_vec[i]) begin
            fa_low = IDX_W'(i);
         end
         if (sa_hit_vec[i]) begin
            sa_low = IDX_W'(i);
         end
      end
      fa_mh = $countones(fa_hit_vec) > 1;
      sa_mh = $countones(sa_hit_vec) > 1;
      dlog = 1'b1;
      if (fa_parity) begin
         next_dsel = `MFSC_SEL_FULL;
         next_didx = fa_parity_idx;
      end else if (sa_parity) begin
         next_dsel = `MFSC_SEL_SET;
         next_didx = sa_parity_idx;
      end else if (sa_mh) begin
         next_dsel = `MFSC_SEL_SET;
         next_didx = sa_low;
      end else if (fa_mh) begin
         next_dsel = `MFSC_SEL_FULL;
         next_didx = fa_low;
      end else begin
         next_dsel = `MFSC_SEL_FULL;
         next_didx = '0;
         dlog = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         data_fault_status_reg <= 64'h0;
      end else if (dtlb_err && dlog) begin
         data_fault_status_reg[`MFSC_B_SEL +: 2] <= next_dsel;
         data_fault_status_reg[`MFSC_B_IDX +: IDX_W] <= next_didx;
      end else if (reg_wr && reg_addr == `MFSC_ADDR_DSTAT) begin
         data_fault_status_reg <= reg_wdata;
      end
   end

   // interrupt: bit0 miss, bit1 exception, bit2 error, bit3 data tlb
   logic [`MFSC_IRQ_W-1:0] irq_ev;
   assign irq_ev = {dtlb_err && dlog, ev == mfsc_pkg::MFSC_EV_ERR,
      ev == mfsc_pkg::MFSC_EV_EXC, ev == mfsc_pkg::MFSC_EV_MISS};

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_stat <= '0;
      end else if (reg_rd && reg_addr == `MFSC_ADDR_IRQ_STAT) begin
         irq_stat <= irq_ev;
      end else begin
         irq_stat <= irq_stat | irq_ev;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_mask <= '0;
      end else if (reg_wr && reg_addr == `MFSC_ADDR_IRQ_MASK) begin
         irq_mask <= reg_wdata[`MFSC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_irq_stat() & irq_mask);
      end
   end

   function automatic logic [`MFSC_IRQ_W-1:0] next_irq_stat();
      return (reg_rd && reg_addr == `MFSC_ADDR_IRQ_STAT) ? irq_ev : (irq_stat | irq_ev);
   endfunction : next_irq_stat

   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= 64'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `MFSC_ADDR_ISTAT: reg_rdata <= instr_fault_status_reg;
            `MFSC_ADDR_DSTAT: reg_rdata <= data_fault_status_reg;
            `MFSC_ADDR_IRQ_STAT: reg_rdata <= {60'h0, irq_stat};
            `MFSC_ADDR_IRQ_MASK: reg_rdata <= {60'h0, irq_mask};
            default: reg_rdata <= 64'h0;
         endcase
      end else begin
         reg_rdata <= 64'h0;
      end
   end

   chk_exc_sets_fv: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_EXC) |=> fv) else $error("fv not set");
   chk_ow_on_fv: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_ERR && fv) |=> instr_fault_status_reg[`MFSC_B_OW])
      else $error("ow not set");
   chk_ft_codes: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_EXC) |=>
      (instr_fault_status_reg[`MFSC_B_FT +: 7] == `MFSC_FT_PRIV ||
      instr_fault_status_reg[`MFSC_B_FT +: 7] == `MFSC_FT_NONE)) else $error("bad ft");
   chk_quiet_hold: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_NONE && !reg_wr) |=> $stable(instr_fault_status_reg))
      else $error("status changed");
   chk_miss_tm: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_MISS) |=> tm) else $error("tm not set");
   chk_ct_nontrans: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_EXC && !ref_asi_translating) |=>
      instr_fault_status_reg[`MFSC_B_CT +: 2] == `MFSC_CT_NONTRANS)
      else $error("ct wrong");
   chk_miss_keeps_fv: assert property (@(posedge mclk) disable iff (srst)
      (ev == mfsc_pkg::MFSC_EV_MISS && fv) |=>
      fv && $stable(instr_fault_status_reg[`MFSC_B_ASI +: 8]))
      else $error("miss over fault changed");
   chk_dtlb_fa_par: assert property (@(posedge mclk) disable iff (srst)
      (dtlb_err && fa_parity) |=> data_fault_status_reg[`MFSC_B_SEL +: 2] == `MFSC_SEL_FULL &&
      data_fault_status_reg[`MFSC_B_IDX +: IDX_W] == $past(fa_parity_idx))
      else $error("dtlb log wrong");
   cov_miss_then_exc: cover property (@(posedge mclk) disable iff (srst)
      ev == mfsc_pkg::MFSC_EV_MISS ##1 ev == mfsc_pkg::MFSC_EV_EXC);
   cov_err_over_exc: cover property (@(posedge mclk) disable iff (srst)
      ev == mfsc_pkg::MFSC_EV_ERR && fv);
   cov_dtlb_mh: cover property (@(posedge mclk) disable iff (srst) dtlb_err && sa_mh);
endmodule : mfsc_capture

// ==== bench/mfsc_fetch_model.sv ====
// Purpose: fetch side model that raises instruction traps
// Assumes: one trap a call, a one-cycle pulse on the rising mclk edge
// Notes: privilege, context and asi fields are scrambled once the trap has been taken; translating flag is held
`timescale 1ns/1ps
module mfsc_fetch_model (
   input wire logic mclk,
   output logic trap_miss,
   output logic trap_exc,
   output logic trap_err,
   output logic page_privileged_bit,
   output logic cpu_privileged_bit,
   output logic [1:0] ref_context,
   output logic ref_asi_translating,
   output logic [7:0] ref_asi
);
   initial begin
      {trap_miss, trap_exc, trap_err} = 3'h0;
      {page_privileged_bit, cpu_privileged_bit, ref_asi_translating} = 3'h0;
      ref_context = 2'h0;
      ref_asi = 8'h80;
   end
   // k: 1 miss, 2 exception, 3 error
   task automatic fire(input logic [1:0] k, input logic pp, input logic cp,
      input logic [1:0] ctx, input logic tr, input logic [7:0] asi);
      @(posedge mclk);
      trap_miss <= (k == 2'h1);
      trap_exc <= (k == 2'h2);
      trap_err <= (k == 2'h3);
      page_privileged_bit <= pp;
      cpu_privileged_bit <= cp;
      ref_context <= ctx;
      ref_asi_translating <= tr;
      ref_asi <= asi;
      @(posedge mclk);
      {trap_miss, trap_exc, trap_err} <= 3'h0;
      {page_privileged_bit, cpu_privileged_bit} <= {~pp, ~cp};
      ref_context <= ~ctx;
      ref_asi <= ~asi;
   endtask : fire
endmodule : mfsc_fetch_model

// ==== bench/test_mmu_fault_status_capture.sv ====
// Purpose: self-checking bench for the fault status capture block
// Assumes: register read data stand one cycle after the read strobe
// Notes: status registers are cleared by software writes between tests
`timescale 1ns/1ps
`include "mfsc_defines.svh"
module test_mmu_fault_status_capture;
   logic mclk, srst, trap_miss, trap_exc, trap_err, pp, cp, tr, ue, nc, dtlb_err;
   logic fa_parity, sa_parity, reg_wr, reg_rd, irq;
   logic [1:0] ctx, bus, itlb, isel;
   logic [7:0] asi;
   logic [10:0] iidx, fa_pidx, sa_pidx;
   logic [2047:0] fa_hit_vec, sa_hit_vec;
   logic [3:0] reg_addr;
   logic [63:0] reg_wdata, reg_rdata, q;
   int error_cnt = 0;
   int cmp_count = 0;
   mfsc_fetch_model i_far (.mclk, .trap_miss, .trap_exc, .trap_err,
      .page_privileged_bit(pp), .cpu_privileged_bit(cp), .ref_context(ctx),
      .ref_asi_translating(tr), .ref_asi(asi));
   mfsc_capture #(.IDX_W(11)) i_dut (.mclk, .srst, .trap_miss, .trap_exc, .trap_err,
      .page_privileged_bit(pp), .cpu_privileged_bit(cp), .ref_context(ctx),
      .ref_asi_translating(tr), .ref_asi(asi), .err_uncorrectable(ue),
      .err_bus_response(bus), .err_itlb(itlb), .err_noncacheable(nc),
      .itlb_select(isel), .itlb_index(iidx), .dtlb_err, .fa_parity,
      .fa_parity_idx(fa_pidx), .sa_parity, .sa_parity_idx(sa_pidx), .fa_hit_vec,
      .sa_hit_vec, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   always #12.5 mclk = ~mclk;
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [63:0] d);
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask : rd
   function automatic logic [63:0] lo(input logic fv, ow, pr, input logic [1:0] ct,
      input logic [6:0] ft, input logic tm);
      return {48'h0, tm, 1'b0, ft, 1'b0, ct, pr, 1'b0, ow, fv};
   endfunction : lo
   task automatic t_exc;
      wr(`MFSC_ADDR_ISTAT, 64'h0);
      i_far.fire(2'h2, 1'b1, 1'b0, 2'h2, 1'b1, 8'h04);
      rd(`MFSC_ADDR_ISTAT);
      chk(q, lo(1, 0, 0, 2'h2, 7'h01, 0) | 64'h04_0000);
      i_far.fire(2'h1, 1'b0, 1'b1, 2'h0, 1'b1, 8'h80);
      rd(`MFSC_ADDR_ISTAT);
      chk(q, lo(1, 0, 0, 2'h2, 7'h01, 1) | 64'h04_0000);
      i_far.fire(2'h2, 1'b1, 1'b0, 2'h0, 1'b0, 8'h80);
      rd(`MFSC_ADDR_ISTAT);
      chk(q, lo(1, 1, 0, 2'h3, 7'h01, 1) | 64'h80_0000);
      $display("test exc done");
   endtask : t_exc
   task automatic t_miss;
      wr(`MFSC_ADDR_ISTAT, 64'h0);
      i_far.fire(2'h1, 1'b0, 1'b1, 2'h0, 1'b1, 8'h80);
      rd(`MFSC_ADDR_ISTAT);
      chk(q[15:0], lo(0, 0, 1, 2'h0, 7'h00, 1));
      i_far.fire(2'h1, 1'b0, 1'b0, 2'h2, 1'b1, 8'h04);
      rd(`MFSC_ADDR_ISTAT);
      chk(q[15:0], lo(0, 0, 0, 2'h2, 7'h00, 1));
      i_far.fire(2'h2, 1'b1, 1'b0, 2'h0, 1'b1, 8'h1e);
      rd(`MFSC_ADDR_ISTAT);
      chk(q[23:0], lo(1, 0, 0, 2'h3, 7'h01, 1) | 64'h1e_0000);
      $display("test miss done");
   endtask : t_miss
   task automatic t_err;
      wr(`MFSC_ADDR_ISTAT, 64'h0);
      {ue, bus, itlb, nc, isel, iidx} <= {1'b1, 2'h2, 2'h1, 1'b1, 2'h2, 11'h5a5};
      i_far.fire(2'h3, 1'b0, 1'b1, 2'h0, 1'b1, 8'h04);
      rd(`MFSC_ADDR_ISTAT);
      chk(q & 64'hcfff_ffff_ffff_ffbb, 64'h8b4a_0000_c604_0009);
      {ue, bus, itlb, nc, isel, iidx} <= {1'b0, 2'h1, 2'h0, 1'b0, 2'h0, 11'h0};
      i_far.fire(2'h3, 1'b0, 1'b0, 2'h2, 1'b1, 8'h80);
      rd(`MFSC_ADDR_ISTAT);
      chk(q[63:49], {2'h2, 2'h0, 11'h5a5});
      chk(q[15:0], lo(1, 1, 0, 2'h2, 7'h00, 0));
      chk(q[30:29], 2'h1);
      $display("test err done");
   endtask : t_err
   task automatic dt(input logic fp, input logic sp, input logic [15:0] fh,
      input logic [15:0] sh, input logic [12:0] e);
      @(posedge mclk);
      {dtlb_err, fa_parity, sa_parity, fa_pidx, sa_pidx} <= {3'h4 | {1'b0, fp, sp}, 11'h003,
         11'h007};
      fa_hit_vec <= {2032'h0, fh};
      sa_hit_vec <= {2032'h0, sh};
      @(posedge mclk);
      dtlb_err <= 1'b0;
      rd(`MFSC_ADDR_DSTAT);
      chk({q[63:62], q[59:49]}, e);
   endtask : dt
   task automatic t_dtlb;
      wr(`MFSC_ADDR_DSTAT, 64'h0);
      dt(1'b1, 1'b1, 16'h000c, 16'h0220, {2'h0, 11'h3});
      dt(1'b0, 1'b1, 16'h000c, 16'h0220, {2'h2, 11'h7});
      dt(1'b0, 1'b0, 16'h000c, 16'h0220, {2'h2, 11'h5});
      dt(1'b0, 1'b0, 16'h0140, 16'h0000, {2'h0, 11'h6});
      $display("test dtlb done");
   endtask : t_dtlb
   task automatic t_irq;
      wr(`MFSC_ADDR_IRQ_MASK, 64'h0);
      rd(`MFSC_ADDR_IRQ_STAT);
      i_far.fire(2'h2, 1'b1, 1'b0, 2'h0, 1'b1, 8'h04);
      @(posedge mclk);
      #1 chk(irq, 1'b0);
      wr(`MFSC_ADDR_IRQ_MASK, 64'h2);
      @(posedge mclk);
      #1 chk(irq, 1'b1);
      rd(`MFSC_ADDR_IRQ_STAT);
      chk(q, 64'h2);
      @(posedge mclk);
      #1 chk(irq, 1'b0);
      rd(4'hf);
      chk(q, 64'h0);
      $display("test irq done");
   endtask : t_irq
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      {mclk, srst, ue, nc, dtlb_err, fa_parity, sa_parity, reg_wr, reg_rd} = 9'h080;
      {bus, itlb, isel, iidx, fa_pidx, sa_pidx, reg_addr} = 43'h0;
      {fa_hit_vec, sa_hit_vec, reg_wdata} = '0;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      rd(`MFSC_ADDR_ISTAT);
      chk(q, 64'h0);
      t_exc;
      t_miss;
      t_err;
      t_dtlb;
      t_irq;
      end_of_test;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      end_of_test;
   end
endmodule : test_mmu_fault_status_capture
